// >>> hdl/sar_adc_pkg.sv
package sar_adc_pkg;

	// ------------------------------------------------------------
	// register addresses (plain port, 4-bit address)
	// ------------------------------------------------------------
	localparam logic [3:0] ADDR_CONTROL0 = 4'h0;
	localparam logic [3:0] ADDR_CONTROL1 = 4'h1;
	localparam logic [3:0] ADDR_RESULT_HIGH = 4'h2;
	localparam logic [3:0] ADDR_RESULT_LOW = 4'h3;
	localparam logic [3:0] ADDR_ANALOG_PIN_SELECT = 4'h4;
	localparam logic [3:0] ADDR_PERIPH_ENABLES_1 = 4'h5;
	localparam logic [3:0] ADDR_PERIPH_FLAGS_1 = 4'h6;
	localparam logic [3:0] ADDR_CORE_CONTROL = 4'h7;

	// ------------------------------------------------------------
	// field positions and reset values
	// ------------------------------------------------------------
	localparam int CTL0_JUSTIFY_BIT = 7;
	localparam int CTL0_REF_BIT = 6;
	localparam int CTL0_CHAN_LSB = 2;
	localparam int CTL0_GO_BIT = 1;
	localparam int CTL0_ON_BIT = 0;
	localparam int CTL1_CLK_LSB = 4;
	localparam int PERIPH_CONV_BIT = 6;
	localparam int CORE_GIE_BIT = 7;
	localparam logic [7:0] PERIPH_IMPL_MASK = 8'h7B;
	localparam logic [7:0] ANALOG_PIN_RESET = 8'hFF;
	localparam logic [7:0] ZERO_BYTE = 8'h00;

	// ------------------------------------------------------------
	// conversion timing
	// ------------------------------------------------------------
	localparam int RESULT_BITS = 10;
	localparam logic [3:0] PERIODS_PER_CONV = 4'hB;
	localparam logic [1:0] ABORT_PERIODS = 2'h2;
	localparam int SYS_CLK_HZ = 40000000;
	localparam int INT_OSC_HZ = 500000;
	localparam int INT_OSC_HALF = SYS_CLK_HZ / INT_OSC_HZ / 2;

	// conversion clock select codes
	localparam logic [2:0] CLKSEL_DIV2 = 3'h0;
	localparam logic [2:0] CLKSEL_DIV4 = 3'h4;
	localparam logic [2:0] CLKSEL_DIV8 = 3'h1;
	localparam logic [2:0] CLKSEL_DIV16 = 3'h5;
	localparam logic [2:0] CLKSEL_DIV32 = 3'h2;
	localparam logic [2:0] CLKSEL_DIV64 = 3'h6;
	localparam logic [1:0] CLKSEL_OSC_LOW = 2'h3;

	// ------------------------------------------------------------
	// carrier types
	// ------------------------------------------------------------
	typedef struct packed {
		logic right_justify;
		logic pos_ref_select;
		logic [3:0] input_channel_select;
		logic conversion_go;
		logic converter_on;
	} control0_type;

	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} bus_req_type;

	typedef enum logic [1:0] {ST_IDLE, ST_CONVERT, ST_RECOVER} seq_state_type;

endpackage

// >>> hdl/conv_clock_gen.sv
`timescale 1ns/1ps
// bit-period tick generator: one tick per conversion period
module conv_clock_gen (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	// control
	input wire logic [2:0] clk_sel_i,
	input wire logic run_i,
	// period strobe
	output logic tick_o
);
	logic [5:0] div_reg;
	logic [6:0] osc_reg;
	logic osc_tick;
	logic [5:0] div_mask;
	logic osc_mode;

	// ------------------------------------------------------------
	// divider selection
	// ------------------------------------------------------------
	// divider counts system clocks so period tracks its frequency
	assign osc_mode = (clk_sel_i[1:0] == sar_adc_pkg::CLKSEL_OSC_LOW);
	assign div_mask = (clk_sel_i == sar_adc_pkg::CLKSEL_DIV2) ? 6'h01 :
		(clk_sel_i == sar_adc_pkg::CLKSEL_DIV4) ? 6'h03 :
		(clk_sel_i == sar_adc_pkg::CLKSEL_DIV8) ? 6'h07 :
		(clk_sel_i == sar_adc_pkg::CLKSEL_DIV16) ? 6'h0F :
		(clk_sel_i == sar_adc_pkg::CLKSEL_DIV32) ? 6'h1F : 6'h3F;
	assign osc_tick = (osc_reg == 7'(2 * sar_adc_pkg::INT_OSC_HALF - 1));
	assign tick_o = run_i & (osc_mode ? osc_tick : ((div_reg & div_mask) == div_mask));

	// divider counts only while running and clears otherwise; the oscillator stand-in runs regardless of mode
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			div_reg <= 6'h00;
			osc_reg <= 7'h00;
		end else begin
			div_reg <= run_i ? div_reg + 6'h01 : 6'h00;
			osc_reg <= osc_tick ? 7'h00 : osc_reg + 7'h01;
		end
	end
endmodule // conv_clock_gen

// >>> hdl/sar_sequencer.sv
`timescale 1ns/1ps
// successive-approximation register, msb first
module sar_sequencer (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	// control
	input wire logic start_i,
	input wire logic tick_i,
	input wire logic comp_i,
	// trial code to the dac, and finished code
	output logic [9:0] trial_o,
	output logic [9:0] code_o
);
	logic [9:0] sar_reg;
	logic [9:0] bit_reg;
	logic [9:0] sar_next;

	// keep the trial bit if comparator says input is above
	assign sar_next = (comp_i ? sar_reg : (sar_reg & ~bit_reg)) | (bit_reg >> 1);
	assign trial_o = sar_reg;
	assign code_o = sar_reg;

	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			sar_reg <= 10'h000;
			bit_reg <= 10'h000;
		end else if (start_i) begin
			sar_reg <= 10'h200;
			bit_reg <= 10'h200;
		end else if (tick_i && bit_reg != 10'h000) begin
			sar_reg <= sar_next; // RULE17
			bit_reg <= bit_reg >> 1;
		end
	end
endmodule // sar_sequencer

// >>> hdl/sar_adc_control.sv
// Function
// RULE1: produce a 10-bit successive-approximation result into result high/low registers.
// RULE2: channel select field routes one analog input to sample-and-hold.
// RULE3: software waits for settling after changing channel before converting.
// RULE4: reference bit picks supply or external pin; negative is ground.
// RULE5: clock select: 000 /2, 100 /4, 001 /8, 101 /16, 010 /32, 110 /64, x11 oscillator.
// RULE6: one bit period resolves one bit; a conversion takes 11 periods.
// RULE7: divided clocks follow system clock; oscillator mode does not.
// RULE8: software picks a setting meeting minimum bit period.
// RULE9: done flag set at every conversion end, regardless of enable.
// RULE10: only software clears the done flag.
// RULE11: interrupt when done flag and its enable are both set.
// RULE12: completion interrupt wakes a sleeping core; next instruction runs first.
// RULE13: after wake, vector to handler only when global enable set.
// RULE14: software sets pin direction and analog select for analog pins.
// RULE15: go with converter on starts; completion clears go, flags, stores result.
// RULE16: go cleared early keeps old result; re-acquire after two periods.
// RULE17: resolve bits msb first, one per period, extra period for disconnect.
// RULE18: unimplemented flag and enable bits read zero, ignore writes.
`timescale 1ns/1ps
module sar_adc_control (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	// register port
	input wire logic [3:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	// analog front end
	input wire logic comp_i,
	output logic [3:0] chan_sel_o,
	output logic pos_ref_ext_o,
	output logic sample_o,
	output logic [9:0] dac_code_o,
	output logic [7:0] analog_pin_select_o,
	// other peripheral flag sources and core state
	input wire logic [7:0] periph_event_i,
	input wire logic sleeping_i,
	// to the core
	output logic irq_o,
	output logic wake_o,
	output logic vector_o
);
	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	sar_adc_pkg::control0_type ctl0_reg;
	logic [2:0] clk_sel_reg;
	logic [7:0] res_high_reg;
	logic [7:0] res_low_reg;
	logic [7:0] analog_pin_select_reg;
	logic [7:0] pie_reg;
	logic [7:0] pir_reg;
	logic gie_reg;
	logic [7:0] rdata_reg;
	sar_adc_pkg::seq_state_type state_reg;
	sar_adc_pkg::seq_state_type state_next;
	logic [3:0] period_reg;
	logic [1:0] recov_reg;
	sar_adc_pkg::bus_req_type req;

	// ------------------------------------------------------------
	// decode
	// ------------------------------------------------------------
	logic wr_ctl0, wr_ctl1, wr_analog_pin_select, wr_pie, wr_pir, wr_core;
	logic tick, run, start, done, abort, go_clear_sw;
	logic [9:0] code;
	logic [7:0] pir_set, rd_mux, ctl0_bits;
	logic [7:0] ctl1_bits, core_bits, ev_masked;
	logic [3:0] period_next;
	logic [1:0] recov_next;
	logic sar_tick;

	// one write strobe per writable register
	assign req = '{addr: reg_addr_i, wdata: reg_wdata_i, wr: reg_wr_i, rd: reg_rd_i};
	assign wr_ctl0 = req.wr && req.addr == sar_adc_pkg::ADDR_CONTROL0;
	assign wr_ctl1 = req.wr && req.addr == sar_adc_pkg::ADDR_CONTROL1;
	assign wr_analog_pin_select = req.wr && req.addr == sar_adc_pkg::ADDR_ANALOG_PIN_SELECT;
	assign wr_pie = req.wr && req.addr == sar_adc_pkg::ADDR_PERIPH_ENABLES_1;
	assign wr_pir = req.wr && req.addr == sar_adc_pkg::ADDR_PERIPH_FLAGS_1;
	assign wr_core = req.wr && req.addr == sar_adc_pkg::ADDR_CORE_CONTROL;

	// start needs go and on; ignored while recovering from an abort
	assign start = state_reg == sar_adc_pkg::ST_IDLE && ctl0_reg.conversion_go
		&& ctl0_reg.converter_on; // RULE15
	assign go_clear_sw = wr_ctl0 && !req.wdata[sar_adc_pkg::CTL0_GO_BIT];
	// turning the converter off also abandons a conversion
	assign abort = state_reg == sar_adc_pkg::ST_CONVERT && (go_clear_sw
		|| (wr_ctl0 && !req.wdata[sar_adc_pkg::CTL0_ON_BIT]));
	// an abort in the last period wins over completion
	assign done = state_reg == sar_adc_pkg::ST_CONVERT && tick && !abort
		&& period_reg == sar_adc_pkg::PERIODS_PER_CONV - 4'h1; // RULE6
	// divider runs through conversion and recovery
	assign run = state_reg != sar_adc_pkg::ST_IDLE;
	assign sample_o = state_reg == sar_adc_pkg::ST_IDLE && ctl0_reg.converter_on;

	// counters only move on ticks, and clear outside their own state
	assign period_next = (state_reg != sar_adc_pkg::ST_CONVERT) ? 4'h0 :
		tick ? period_reg + 4'h1 : period_reg;
	assign recov_next = (state_reg != sar_adc_pkg::ST_RECOVER) ? 2'h0 :
		tick ? recov_reg + 2'h1 : recov_reg;

	// sequencer steps only while converting
	assign sar_tick = tick && state_reg == sar_adc_pkg::ST_CONVERT;

	// ------------------------------------------------------------
	// sequencer state
	// ------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			sar_adc_pkg::ST_IDLE: begin
				if (start) begin
					state_next = sar_adc_pkg::ST_CONVERT;
				end
			end
			sar_adc_pkg::ST_CONVERT: begin
				if (abort) begin
					state_next = sar_adc_pkg::ST_RECOVER; // RULE16
				end else if (done) begin
					state_next = sar_adc_pkg::ST_IDLE;
				end
			end
			// recovery waits two periods before the next acquisition
			sar_adc_pkg::ST_RECOVER: begin
				if (tick && recov_reg == sar_adc_pkg::ABORT_PERIODS - 2'h1) begin
					state_next = sar_adc_pkg::ST_IDLE; // RULE16
				end
			end
		endcase
	end

	// sequencer state
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state_reg <= sar_adc_pkg::ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// bit periods elapsed in this conversion
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			period_reg <= 4'h0;
		end else begin
			period_reg <= period_next;
		end
	end

	// bit periods elapsed since an abort
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			recov_reg <= 2'h0;
		end else begin
			recov_reg <= recov_next;
		end
	end

	// ------------------------------------------------------------
	// submodules
	// ------------------------------------------------------------
	conv_clock_gen u_clk (
		.ref_clk_i(ref_clk_i),
		.sys_rst_i(sys_rst_i),
		.clk_sel_i(clk_sel_reg), // RULE5 RULE7
		.run_i(run),
		.tick_o(tick)
	);

	sar_sequencer u_sar (
		.ref_clk_i(ref_clk_i),
		.sys_rst_i(sys_rst_i),
		.start_i(start),
		.tick_i(sar_tick),
		.comp_i(comp_i),
		.trial_o(dac_code_o),
		.code_o(code)
	);

	// ------------------------------------------------------------
	// control and configuration registers
	// ------------------------------------------------------------
	// hardware clear of go on completion; it yields to a software write in that cycle
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ctl0_reg <= '0;
		end else if (wr_ctl0) begin
			ctl0_reg <= sar_adc_pkg::control0_type'(req.wdata); // RULE2 RULE4
		end else if (done) begin
			ctl0_reg.conversion_go <= 1'b0; // RULE15
		end
	end

	// conversion clock select
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			clk_sel_reg <= 3'h0;
		end else if (wr_ctl1) begin
			clk_sel_reg <= req.wdata[sar_adc_pkg::CTL1_CLK_LSB +: 3];
		end
	end

	// analog pin select, all analog out of reset
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			analog_pin_select_reg <= sar_adc_pkg::ANALOG_PIN_RESET;
		end else if (wr_analog_pin_select) begin
			analog_pin_select_reg <= req.wdata;
		end
	end

	// interrupt enables, unimplemented bits held at zero
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			pie_reg <= sar_adc_pkg::ZERO_BYTE;
		end else if (wr_pie) begin
			pie_reg <= req.wdata & sar_adc_pkg::PERIPH_IMPL_MASK; // RULE18
		end
	end

	// global enable, decides vectoring after a wake
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			gie_reg <= 1'b0;
		end else if (wr_core) begin
			gie_reg <= req.wdata[sar_adc_pkg::CORE_GIE_BIT];
		end
	end

	// ------------------------------------------------------------
	// result and flag registers
	// ------------------------------------------------------------
	// other sources never touch the conversion flag bit
	assign ev_masked = periph_event_i & sar_adc_pkg::PERIPH_IMPL_MASK
		& ~({7'h00, 1'b1} << sar_adc_pkg::PERIPH_CONV_BIT);
	assign pir_set = ev_masked | ({7'h00, done} << sar_adc_pkg::PERIPH_CONV_BIT);

	// results only load on a full conversion, so an abort keeps the old pair
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			res_high_reg <= sar_adc_pkg::ZERO_BYTE;
			res_low_reg <= sar_adc_pkg::ZERO_BYTE;
		end else if (done && ctl0_reg.right_justify) begin
			res_high_reg <= {6'h00, code[9:8]}; // RULE1
			res_low_reg <= code[7:0];
		end else if (done) begin
			res_high_reg <= code[9:2]; // RULE1
			res_low_reg <= {code[1:0], 6'h00};
		end
	end

	// write-one-to-clear; a set in the same cycle wins
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			pir_reg <= sar_adc_pkg::ZERO_BYTE;
		end else begin
			pir_reg <= ((wr_pir ? pir_reg & ~req.wdata : pir_reg) | pir_set)
				& sar_adc_pkg::PERIPH_IMPL_MASK; // RULE9 RULE10 RULE18
		end
	end

	// ------------------------------------------------------------
	// interrupt, wake and vector
	// ------------------------------------------------------------
	// level request, dropped only through the flag or enable register
	assign irq_o = |(pir_reg & pie_reg); // RULE11
	assign wake_o = irq_o && sleeping_i; // RULE12
	assign vector_o = irq_o && gie_reg; // RULE13

	// ------------------------------------------------------------
	// read port
	// ------------------------------------------------------------
	// register images, unimplemented bits as zero
	assign ctl0_bits = 8'(ctl0_reg);
	assign ctl1_bits = {1'b0, clk_sel_reg, 4'h0};
	assign core_bits = {gie_reg, 7'h00};
	// unmapped addresses read as zero
	assign rd_mux = (req.addr == sar_adc_pkg::ADDR_CONTROL0) ? ctl0_bits :
		(req.addr == sar_adc_pkg::ADDR_CONTROL1) ? ctl1_bits :
		(req.addr == sar_adc_pkg::ADDR_RESULT_HIGH) ? res_high_reg :
		(req.addr == sar_adc_pkg::ADDR_RESULT_LOW) ? res_low_reg :
		(req.addr == sar_adc_pkg::ADDR_ANALOG_PIN_SELECT) ? analog_pin_select_reg :
		(req.addr == sar_adc_pkg::ADDR_PERIPH_ENABLES_1) ? pie_reg :
		(req.addr == sar_adc_pkg::ADDR_PERIPH_FLAGS_1) ? pir_reg :
		(req.addr == sar_adc_pkg::ADDR_CORE_CONTROL) ? core_bits :
		sar_adc_pkg::ZERO_BYTE;

	// read data valid the cycle after the strobe only
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rdata_reg <= sar_adc_pkg::ZERO_BYTE;
		end else begin
			rdata_reg <= req.rd ? rd_mux : sar_adc_pkg::ZERO_BYTE;
		end
	end

	// outputs straight from registers
	assign reg_rdata_o = rdata_reg;
	assign chan_sel_o = ctl0_reg.input_channel_select; // RULE2
	assign pos_ref_ext_o = ctl0_reg.pos_ref_select; // RULE4
	assign analog_pin_select_o = analog_pin_select_reg;
endmodule // sar_adc_control

// >>> tb/sar_adc_control_monitor.sv
`timescale 1ns/1ps
// ----------------------------------------
// port checker for the converter control
// ----------------------------------------
module sar_adc_control_monitor (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	// register port
	input wire logic [3:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_rdata_o,
	// analog front end
	input wire logic comp_i,
	input wire logic [3:0] chan_sel_o,
	input wire logic pos_ref_ext_o,
	input wire logic sample_o,
	input wire logic [9:0] dac_code_o,
	input wire logic [7:0] analog_pin_select_o,
	// flag sources and core
	input wire logic [7:0] periph_event_i,
	input wire logic sleeping_i,
	input wire logic irq_o,
	input wire logic wake_o,
	input wire logic vector_o
);
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (sys_rst_i);
	// decoded strobes
	wire ctl_wr = reg_wr_i && reg_addr_i == sar_adc_pkg::ADDR_CONTROL0;
	wire en_wr = reg_wr_i && reg_addr_i == sar_adc_pkg::ADDR_PERIPH_ENABLES_1;
	wire pin_wr = reg_wr_i && reg_addr_i == sar_adc_pkg::ADDR_ANALOG_PIN_SELECT;
	wire pe_rd = reg_rd_i && reg_addr_i inside {4'h5, 4'h6};
	property p_rdata_zero;
		(!reg_rd_i || reg_addr_i[3]) |=> reg_rdata_o == 8'h00;
	endproperty
	a_rdata_zero: assert property (p_rdata_zero) else $error("stray read data");
	property p_unimpl;
		pe_rd |=> (reg_rdata_o & ~sar_adc_pkg::PERIPH_IMPL_MASK) == 8'h00;
	endproperty
	a_unimpl: assert property (p_unimpl) else $error("unused flag bit set");
	property p_ctl0;
		ctl_wr |=> chan_sel_o == $past(reg_wdata_i[5:2]) && pos_ref_ext_o == $past(reg_wdata_i[6]);
	endproperty
	a_ctl0: assert property (p_ctl0) else $error("channel or reference wrong");
	property p_start;
		(ctl_wr && reg_wdata_i[1:0] == 2'h3 && sample_o) |-> ##[1:3] !sample_o;
	endproperty
	a_start: assert property (p_start) else $error("conversion did not start");
	property p_sticky;
		irq_o && !reg_wr_i |=> irq_o;
	endproperty
	a_sticky: assert property (p_sticky) else $error("flag cleared itself");
	property p_mask;
		en_wr && reg_wdata_i == 8'h00 |=> !irq_o;
	endproperty
	a_mask: assert property (p_mask) else $error("masked interrupt seen");
	property p_wake;
		wake_o == (irq_o && sleeping_i);
	endproperty
	a_wake: assert property (p_wake) else $error("wake mismatch");
	property p_vector;
		vector_o |-> irq_o;
	endproperty
	a_vector: assert property (p_vector) else $error("vector without request");
	property p_pin;
		pin_wr |=> analog_pin_select_o == $past(reg_wdata_i);
	endproperty
	a_pin: assert property (p_pin) else $error("pin select not updated");
	c_irq: cover property ($rose(irq_o));
	c_wake: cover property (wake_o);
	c_vector: cover property (vector_o);
endmodule // sar_adc_control_monitor

bind sar_adc_control sar_adc_control_monitor u_mon (.ref_clk_i(ref_clk_i),
	.sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
	.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .comp_i(comp_i),
	.chan_sel_o(chan_sel_o), .pos_ref_ext_o(pos_ref_ext_o), .sample_o(sample_o),
	.dac_code_o(dac_code_o), .analog_pin_select_o(analog_pin_select_o),
	.periph_event_i(periph_event_i), .sleeping_i(sleeping_i), .irq_o(irq_o),
	.wake_o(wake_o), .vector_o(vector_o));

// >>> tb/analog_front_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// analog inputs, sample-hold and comparator
// ----------------------------------------
module analog_front_model (
	// clock
	input wire logic ref_clk_i,
	// from the converter
	input wire logic [3:0] chan_sel_i,
	input wire logic pos_ref_ext_i,
	input wire logic sample_i,
	input wire logic [9:0] dac_code_i,
	// scene from the bench
	input wire logic [9:0] base_i,
	// comparator decision
	output logic comp_o
);
	logic [9:0] held_reg;
	// each channel offset from the base level, ground is the low reference
	wire [9:0] raw = base_i + {1'h0, chan_sel_i, 5'h05};
	wire [9:0] lvl = pos_ref_ext_i ? {1'h0, raw[9:1]} : raw;
	// level frozen once acquisition ends
	always @(posedge ref_clk_i) begin
		if (sample_i) begin
			held_reg <= lvl;
		end
	end
	// half a step up so no trial ever ties
	assign comp_o = {held_reg, 1'h1} > {dac_code_i, 1'h0};
endmodule // analog_front_model

// >>> tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	localparam logic [3:0] A_C0 = sar_adc_pkg::ADDR_CONTROL0;
	localparam logic [3:0] A_C1 = sar_adc_pkg::ADDR_CONTROL1;
	localparam logic [3:0] A_EN = sar_adc_pkg::ADDR_PERIPH_ENABLES_1;
	localparam logic [3:0] A_FL = sar_adc_pkg::ADDR_PERIPH_FLAGS_1;
	logic ref_clk_i = 1'h0, sys_rst_i = 1'h1, wr = 1'h0, rd = 1'h0, slp = 1'h0, rd_seen = 1'h0;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00, ev = 8'h00, last_ctl, exp_hi, exp_lo;
	logic [9:0] base = 10'h000;
	logic [31:0] rnd = 32'hCB17;
	logic [7:0] exp_q[$];
	wire comp, ref_ext, sample, irq, wake, vect;
	wire [3:0] chan;
	wire [7:0] rdata, pins;
	wire [9:0] dac;
	int err_total = 0, checked = 0;
	always #12.5 ref_clk_i = ~ref_clk_i;
	sar_adc_control u_dut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(addr),
		.reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .comp_i(comp),
		.chan_sel_o(chan), .pos_ref_ext_o(ref_ext), .sample_o(sample), .dac_code_o(dac),
		.analog_pin_select_o(pins), .periph_event_i(ev), .sleeping_i(slp), .irq_o(irq),
		.wake_o(wake), .vector_o(vect));
	analog_front_model u_front (.ref_clk_i(ref_clk_i), .chan_sel_i(chan),
		.pos_ref_ext_i(ref_ext), .sample_i(sample), .dac_code_i(dac), .base_i(base),
		.comp_o(comp));
	// ----------------------------------------
	// bus, compare and closing tasks
	// ----------------------------------------
	task automatic cmp(input string name, input logic [15:0] e, input logic [15:0] g);
		checked++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", name, e, g);
		end
	endtask
	task automatic bwr(input logic [3:0] a, input logic [7:0] d);
		@(posedge ref_clk_i);
		addr <= a;
		wdata <= d;
		wr <= 1'h1;
		@(posedge ref_clk_i);
		wr <= 1'h0;
	endtask
	task automatic brd(input logic [3:0] a, input logic [7:0] e);
		@(posedge ref_clk_i);
		addr <= a;
		rd <= 1'h1;
		exp_q.push_back(e);
		@(posedge ref_clk_i);
		rd <= 1'h0;
	endtask
	task automatic settle;
		repeat (2) @(posedge ref_clk_i);
		#1;
	endtask
	task automatic end_sim;
		if (err_total == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	// one conversion on a random channel, reference and format
	task automatic convert(input logic [2:0] k);
		int cyc;
		int d;
		logic [9:0] r;
		d = k[1:0] == 2'h3 ? 2 * sar_adc_pkg::INT_OSC_HALF : 2 << ({k[1:0], 1'h0} + k[2]);
		rnd = lfsr(rnd);
		base <= rnd[9:0];
		last_ctl = {rnd[14:13], 1'h0, rnd[12:10], 2'h1};
		r = rnd[9:0] + {2'h0, rnd[12:10], 5'h05};
		r = rnd[13] ? {1'h0, r[9:1]} : r;
		exp_hi = rnd[14] ? {6'h00, r[9:8]} : r[9:2];
		exp_lo = rnd[14] ? r[7:0] : {r[1:0], 6'h00};
		bwr(A_C1, {1'h0, k, 4'h0});
		bwr(A_C0, last_ctl);
		repeat (8) @(posedge ref_clk_i);
		bwr(A_C0, last_ctl | 8'h02);
		cyc = 1;
		while ((sample !== 1'h1 || cyc < 3) && cyc < 2000) begin
			@(posedge ref_clk_i);
			cyc++;
		end
		cmp("conv_cycles_ok", 16'h0001, 16'(cyc >= 10 * d && cyc <= 12 * d + 6));
		brd(sar_adc_pkg::ADDR_RESULT_HIGH, exp_hi);
		brd(sar_adc_pkg::ADDR_RESULT_LOW, exp_lo);
		brd(A_C0, last_ctl);
	endtask
	// read data checked against the oldest note, one cycle after the strobe
	always @(posedge ref_clk_i) begin
		if (rd_seen) begin
			cmp("reg_rdata_o", {8'h00, exp_q.pop_front()}, {8'h00, rdata});
		end
		rd_seen <= rd;
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (6) @(posedge ref_clk_i);
		sys_rst_i <= 1'h0;
		for (int a = 0; a < 16; a++) begin
			brd(4'(a), a == 4 ? sar_adc_pkg::ANALOG_PIN_RESET : 8'h00);
		end
		bwr(4'h9, 8'hFF);
		brd(4'h9, 8'h00);
		bwr(A_EN, 8'hFF);
		brd(A_EN, sar_adc_pkg::PERIPH_IMPL_MASK);
		bwr(A_EN, 8'h00);
		bwr(sar_adc_pkg::ADDR_ANALOG_PIN_SELECT, 8'h0F);
		brd(sar_adc_pkg::ADDR_ANALOG_PIN_SELECT, 8'h0F);
		rnd = lfsr(rnd);
		@(posedge ref_clk_i) ev <= rnd[7:0];
		@(posedge ref_clk_i) ev <= 8'h00;
		brd(A_FL, rnd[7:0] & 8'h3B);
		bwr(A_FL, 8'hFF);
		brd(A_FL, 8'h00);
		for (int k = 0; k < 8; k++) begin
			convert(3'(k));
			brd(A_FL, 8'h40);
			bwr(A_FL, 8'h40);
		end
		// enabled completion, sleep and vectoring
		bwr(A_EN, 8'h40);
		convert(3'h0);
		settle;
		cmp("irq_o", 16'h0001, {15'h0000, irq});
		@(posedge ref_clk_i) slp <= 1'h1;
		bwr(sar_adc_pkg::ADDR_CORE_CONTROL, 8'h80);
		settle;
		cmp("wake_o", 16'h0001, {15'h0000, wake});
		cmp("vector_o", 16'h0001, {15'h0000, vect});
		bwr(A_EN, 8'h00);
		settle;
		cmp("irq_o", 16'h0000, {15'h0000, irq});
		brd(A_FL, 8'h40);
		bwr(A_EN, 8'h40);
		bwr(A_FL, 8'h40);
		settle;
		cmp("wake_o", 16'h0000, {15'h0000, wake});
		@(posedge ref_clk_i) slp <= 1'h0;
		bwr(sar_adc_pkg::ADDR_CORE_CONTROL, 8'h00);
		// abort mid-conversion keeps old result, recovery takes two periods
		bwr(A_C1, 8'h60);
		bwr(A_C0, last_ctl | 8'h02);
		repeat (100) @(posedge ref_clk_i);
		bwr(A_C0, last_ctl);
		repeat (40) @(posedge ref_clk_i);
		#1;
		cmp("sample_o", 16'h0000, {15'h0000, sample});
		repeat (160) @(posedge ref_clk_i);
		#1;
		cmp("sample_o", 16'h0001, {15'h0000, sample});
		brd(A_FL, 8'h00);
		brd(sar_adc_pkg::ADDR_RESULT_HIGH, exp_hi);
		brd(sar_adc_pkg::ADDR_RESULT_LOW, exp_lo);
		settle;
		end_sim;
	end
	// hang guard, well beyond the longest expected run
	initial begin
		repeat (20000) @(posedge ref_clk_i);
		err_total++;
		end_sim;
	end
endmodule // tb_top
